// ### hdl/pmcb_map.svh
`ifndef PMCB_MAP_SVH
`define PMCB_MAP_SVH
// How it works
// - Output format fixed: unsigned linear, exponent -10
// - Channel A setpoint from strap; B 0x0333
// - Strap gives A ceiling 0x077A, else stored
// - Overvoltage trip default setpoint plus 192 mV
// - Overvoltage caution setpoint plus 176 mV, warn only
// - Undervoltage caution setpoint minus 176 mV
// - Undervoltage trip setpoint minus 192 mV
// - Undervoltage latches off after 5 us
// - Other fault actions latch off, no restart
// - Input alert mask resets to 0x08
// - Misc alert mask reads 0x0D, fixed
// - Other alert masks reset 0x00, maker 0x06
// - Phase mode resets 0x03, never stored
// - Current offset default 0xE800, whole channel
// - Overcurrent trip has total and phase limits
// - Page 0 A, 1 B, 0xFF both
// - Store copies storable registers to memory
// - Restore reloads storable registers from memory
`define PMCB_C_PAGE    8'h00
`define PMCB_C_CLEAR   8'h03
`define PMCB_C_STORE   8'h15
`define PMCB_C_RESTORE 8'h16
`define PMCB_C_MASK    8'h1B
`define PMCB_C_VMODE   8'h20
`define PMCB_C_VCMD    8'h21
`define PMCB_C_TRIM    8'h22
`define PMCB_C_VMAX    8'h24
`define PMCB_C_MHI     8'h25
`define PMCB_C_MLO     8'h26
`define PMCB_C_SLEW    8'h27
`define PMCB_C_DROOP   8'h28
`define PMCB_C_SCALE   8'h29
`define PMCB_C_VMIN    8'h2B
`define PMCB_C_FSW     8'h33
`define PMCB_C_PMODE   8'h34
`define PMCB_C_VINON   8'h35
`define PMCB_C_GAIN    8'h38
`define PMCB_C_OFFS    8'h39
`define PMCB_C_OVF     8'h40
`define PMCB_C_OVR     8'h41
`define PMCB_C_OVW     8'h42
`define PMCB_C_UVW     8'h43
`define PMCB_C_UVF     8'h44
`define PMCB_C_UVR     8'h45
`define PMCB_C_OCF     8'h46
`define PMCB_C_OCR     8'h47
`define PMCB_C_OCW     8'h4A
`define PMCB_C_OTF     8'h4F
`define PMCB_C_OTR     8'h50
`define PMCB_C_OTW     8'h51
`define PMCB_C_VINOVF  8'h55
`define PMCB_C_VINOVR  8'h56
`define PMCB_C_VINOVW  8'h57
`define PMCB_M_VOUT    8'h7A
`define PMCB_M_IOUT    8'h7B
`define PMCB_M_INPUT   8'h7C
`define PMCB_M_TEMP    8'h7D
`define PMCB_M_CML     8'h7E
`define PMCB_M_OTHER   8'h7F
`define PMCB_M_MFR     8'h80
`define PMCB_PAGE_A    8'h00
`define PMCB_PAGE_B    8'h01
`define PMCB_PAGE_ALL  8'hFF
`define PMCB_VMODE_VAL 16'h0016
`define PMCB_OTHER_VAL 16'h000D
`define PMCB_MINP_RST  16'h0008
`define PMCB_MMFR_RST  16'h0006
`define PMCB_ZERO      16'h0000
`define PMCB_BYTE_MSK  16'h00FF
`define PMCB_VCMD_A    16'h0385
`define PMCB_VCMD_B    16'h0333
`define PMCB_VMAX_PIN  16'h077A
`define PMCB_VMAX_A    16'h04CD
`define PMCB_VMAX_B    16'h059A
`define PMCB_SLEW_RST  16'hE050
`define PMCB_DROOP_RST 16'hC800
`define PMCB_SCALE_RST 16'hE808
`define PMCB_FSW_RST   16'h01F4
`define PMCB_PMODE_RST 16'h0003
`define PMCB_VINON_RST 16'hF025
`define PMCB_GAIN_RST  16'hCA80
`define PMCB_OFFS_RST  16'hE800
`define PMCB_OVF_A     16'h044A
`define PMCB_OVF_B     16'h03F7
`define PMCB_OVW_A     16'h0439
`define PMCB_OVW_B     16'h03E7
`define PMCB_UVW_A     16'h02D1
`define PMCB_UVW_B     16'h027E
`define PMCB_UVF_A     16'h02C0
`define PMCB_UVF_B     16'h026E
`define PMCB_LATCH_RSP 16'h0080
`define PMCB_UV_RSP    16'h0040
`define PMCB_OC_RSP    16'h00C0
`define PMCB_OCF_A     16'h10E0
`define PMCB_OCF_B     16'h0050
`define PMCB_OCPH_RST  16'h0035
`define PMCB_OCW_A     16'h01B8
`define PMCB_OCW_B     16'h003C
`define PMCB_OTF_RST   16'h0078
`define PMCB_OTW_RST   16'h006E
`define PMCB_VINOVF_RST 16'h000F
`define PMCB_VINOVW_RST 16'h000E
`define PMCB_RSP_HI    7
`define PMCB_RSP_LO    6
`define PMCB_UV_DLY_NS 5000
`define PMCB_CLK_NS    5
`define PMCB_SYNC_LAST 2'b10
`endif

// ### hdl/pmcb_pkg.sv
package pmcb_pkg;
  localparam int NSLOT = 36;
  typedef enum logic [5:0] {
    SL_MVOUT, SL_MIOUT, SL_MINP, SL_MTEMP, SL_MCML, SL_MMFR, SL_VCMD, SL_TRIM, SL_VMAX,
    SL_MHI, SL_MLO, SL_SLEW, SL_DROOP, SL_SCALE, SL_VMIN, SL_FSW, SL_PMODE, SL_VINON,
    SL_GAIN, SL_OFFS, SL_OVF, SL_OVR, SL_OVW, SL_UVW, SL_UVF, SL_UVR, SL_OCF, SL_OCPH,
    SL_OCR, SL_OCW, SL_OTF, SL_OTR, SL_OTW, SL_VINOVF, SL_VINOVR, SL_VINOVW
  } pmcb_slot_t;
  typedef enum logic [1:0] {
    ST_SYNC = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } pmcb_state_t;
  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] iphase;
    logic [15:0] temp;
  } pmcb_meas_t;
endpackage : pmcb_pkg

// ### hdl/pmcb_bank.sv
`include "pmcb_map.svh"
module pmcb_bank import pmcb_pkg::*; #(
  parameter int UV_CNT_W = 11
) (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // Command port
  input  wire logic                   cmd_valid_in,
  input  wire logic                   cmd_write_in,
  input  wire logic [7:0]             cmd_code_in,
  input  wire logic [7:0]             cmd_sub_in,
  input  wire logic [15:0]            cmd_data_in,
  output logic      [15:0]            rd_data_out,
  output logic                        rd_valid_out,
  output logic                        cmd_err_out,
  // Pins
  input  wire logic                   boot_voltage_strap_a_in,
  input  wire logic [15:0]            boot_code_in,
  input  wire logic [1:0]             chan_en_in,
  // Telemetry
  input  wire pmcb_meas_t [1:0]       meas_in,
  input  wire logic [15:0]            vin_in,
  // Status
  output logic                        ready_out,
  output logic      [1:0]             chan_on_out,
  output logic      [1:0]             fault_out,
  output logic      [1:0]             warn_out,
  output logic      [1:0][15:0]       setpoint_out
);
  localparam int UV_CYC = (`PMCB_UV_DLY_NS + `PMCB_CLK_NS - 1) / `PMCB_CLK_NS;
  localparam logic [UV_CNT_W-1:0] UV_LAST = UV_CNT_W'(UV_CYC - 1);

  if (UV_CYC >= (1 << UV_CNT_W)) begin : g_chk
    $error("UV_CNT_W too narrow for the undervoltage delay");
  end

  logic [15:0]         regs [2][NSLOT];
  logic [15:0]         nvm  [2][NSLOT];
  logic [7:0]          page_reg;
  pmcb_state_t         state_reg;
  logic [1:0]          wait_reg;
  logic                strap_m_reg, strap_s_reg;
  logic [15:0]         code_m_reg, code_s_reg;
  logic [1:0]          en_m_reg, en_s_reg;
  logic [UV_CNT_W-1:0] dly_cnt_reg [2];
  logic [1:0]          imm_trip, del_trip, clr_hit, sel;
  logic [6:0]          dec;
  pmcb_slot_t          slot;
  logic                run, wr, rd, ro_hit;

  function automatic logic [6:0] decode(input logic [7:0] c, input logic [7:0] s);
    case (c)
      `PMCB_C_MASK: begin
        case (s)
          `PMCB_M_VOUT:  decode = {1'b1, SL_MVOUT};
          `PMCB_M_IOUT:  decode = {1'b1, SL_MIOUT};
          `PMCB_M_INPUT: decode = {1'b1, SL_MINP};
          `PMCB_M_TEMP:  decode = {1'b1, SL_MTEMP};
          `PMCB_M_CML:   decode = {1'b1, SL_MCML};
          `PMCB_M_MFR:   decode = {1'b1, SL_MMFR};
          default:       decode = 7'h00;
        endcase
      end
      `PMCB_C_VCMD:   decode = {1'b1, SL_VCMD};
      `PMCB_C_TRIM:   decode = {1'b1, SL_TRIM};
      `PMCB_C_VMAX:   decode = {1'b1, SL_VMAX};
      `PMCB_C_MHI:    decode = {1'b1, SL_MHI};
      `PMCB_C_MLO:    decode = {1'b1, SL_MLO};
      `PMCB_C_SLEW:   decode = {1'b1, SL_SLEW};
      `PMCB_C_DROOP:  decode = {1'b1, SL_DROOP};
      `PMCB_C_SCALE:  decode = {1'b1, SL_SCALE};
      `PMCB_C_VMIN:   decode = {1'b1, SL_VMIN};
      `PMCB_C_FSW:    decode = {1'b1, SL_FSW};
      `PMCB_C_PMODE:  decode = {1'b1, SL_PMODE};
      `PMCB_C_VINON:  decode = {1'b1, SL_VINON};
      `PMCB_C_GAIN:   decode = {1'b1, SL_GAIN};
      `PMCB_C_OFFS:   decode = {1'b1, SL_OFFS};
      `PMCB_C_OVF:    decode = {1'b1, SL_OVF};
      `PMCB_C_OVR:    decode = {1'b1, SL_OVR};
      `PMCB_C_OVW:    decode = {1'b1, SL_OVW};
      `PMCB_C_UVW:    decode = {1'b1, SL_UVW};
      `PMCB_C_UVF:    decode = {1'b1, SL_UVF};
      `PMCB_C_UVR:    decode = {1'b1, SL_UVR};
      `PMCB_C_OCF:    decode = s[0] ? {1'b1, SL_OCPH} : {1'b1, SL_OCF};
      `PMCB_C_OCR:    decode = {1'b1, SL_OCR};
      `PMCB_C_OCW:    decode = {1'b1, SL_OCW};
      `PMCB_C_OTF:    decode = {1'b1, SL_OTF};
      `PMCB_C_OTR:    decode = {1'b1, SL_OTR};
      `PMCB_C_OTW:    decode = {1'b1, SL_OTW};
      `PMCB_C_VINOVF: decode = {1'b1, SL_VINOVF};
      `PMCB_C_VINOVR: decode = {1'b1, SL_VINOVR};
      `PMCB_C_VINOVW: decode = {1'b1, SL_VINOVW};
      default:        decode = 7'h00;
    endcase
  endfunction : decode

  function automatic logic [15:0] dflt(input logic b, input int s);
    case (s)
      SL_MINP:   dflt = `PMCB_MINP_RST;
      SL_MMFR:   dflt = `PMCB_MMFR_RST;
      SL_VCMD:   dflt = b ? `PMCB_VCMD_B : `PMCB_VCMD_A;
      SL_VMAX:   dflt = b ? `PMCB_VMAX_B : `PMCB_VMAX_A;
      SL_SLEW:   dflt = `PMCB_SLEW_RST;
      SL_DROOP:  dflt = `PMCB_DROOP_RST;
      SL_SCALE:  dflt = `PMCB_SCALE_RST;
      SL_FSW:    dflt = `PMCB_FSW_RST;
      SL_PMODE:  dflt = `PMCB_PMODE_RST;
      SL_VINON:  dflt = `PMCB_VINON_RST;
      SL_GAIN:   dflt = `PMCB_GAIN_RST;
      SL_OFFS:   dflt = `PMCB_OFFS_RST;
      SL_OVF:    dflt = b ? `PMCB_OVF_B : `PMCB_OVF_A;
      SL_OVW:    dflt = b ? `PMCB_OVW_B : `PMCB_OVW_A;
      SL_UVW:    dflt = b ? `PMCB_UVW_B : `PMCB_UVW_A;
      SL_UVF:    dflt = b ? `PMCB_UVF_B : `PMCB_UVF_A;
      SL_UVR:    dflt = `PMCB_UV_RSP;
      SL_OCF:    dflt = b ? `PMCB_OCF_B : `PMCB_OCF_A;
      SL_OCPH:   dflt = `PMCB_OCPH_RST;
      SL_OCR:    dflt = `PMCB_OC_RSP;
      SL_OVR, SL_OTR, SL_VINOVR: dflt = `PMCB_LATCH_RSP;
      SL_OCW:    dflt = b ? `PMCB_OCW_B : `PMCB_OCW_A;
      SL_OTF:    dflt = `PMCB_OTF_RST;
      SL_OTW:    dflt = `PMCB_OTW_RST;
      SL_VINOVF: dflt = `PMCB_VINOVF_RST;
      SL_VINOVW: dflt = `PMCB_VINOVW_RST;
      default:   dflt = `PMCB_ZERO;
    endcase
  endfunction : dflt

  // Margins and phase mode are volatile
  function automatic logic storable(input int s);
    storable = !(s == SL_MHI || s == SL_MLO || s == SL_PMODE);
  endfunction : storable

  function automatic logic is_byte(input int s);
    is_byte = s <= SL_MMFR || s == SL_PMODE || s == SL_OVR || s == SL_UVR ||
              s == SL_OCR || s == SL_OTR || s == SL_VINOVR;
  endfunction : is_byte

  // Split a response code into immediate and delayed latch-off
  function automatic logic [1:0] trip(input logic f, input logic [15:0] r);
    trip = {f & r[`PMCB_RSP_HI], f & !r[`PMCB_RSP_HI] & r[`PMCB_RSP_LO]};
  endfunction : trip

  assign run    = state_reg == ST_RUN;
  assign wr     = run && cmd_valid_in && cmd_write_in;
  assign rd     = run && cmd_valid_in && !cmd_write_in;
  assign dec    = decode(cmd_code_in, cmd_sub_in);
  assign slot   = pmcb_slot_t'(dec[5:0]);
  assign ro_hit = cmd_code_in == `PMCB_C_VMODE ||
                  (cmd_code_in == `PMCB_C_MASK && cmd_sub_in == `PMCB_M_OTHER);
  assign sel[0] = page_reg == `PMCB_PAGE_ALL || page_reg == `PMCB_PAGE_A;
  assign sel[1] = page_reg == `PMCB_PAGE_ALL || page_reg == `PMCB_PAGE_B;
  assign clr_hit = (wr && cmd_code_in == `PMCB_C_CLEAR) ? sel : 2'b00;
  assign setpoint_out[0] = regs[0][SL_VCMD];
  assign setpoint_out[1] = regs[1][SL_VCMD];

  // Pins pass two flops; the strap code is static so per-bit sync is safe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_m_reg <= 1'b0;
      strap_s_reg <= 1'b0;
      code_m_reg  <= `PMCB_ZERO;
      code_s_reg  <= `PMCB_ZERO;
      en_m_reg    <= 2'b00;
      en_s_reg    <= 2'b00;
    end else begin
      strap_m_reg <= boot_voltage_strap_a_in;
      strap_s_reg <= strap_m_reg;
      code_m_reg  <= boot_code_in;
      code_s_reg  <= code_m_reg;
      en_m_reg    <= chan_en_in;
      en_s_reg    <= en_m_reg;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_SYNC;
      wait_reg  <= 2'b00;
    end else begin
      case (state_reg)
        ST_SYNC: begin
          // Wait out the pin synchronisers so the load sees a settled strap
          wait_reg <= wait_reg + 2'b01;
          if (wait_reg == `PMCB_SYNC_LAST) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: state_reg <= ST_RUN;
        ST_RUN:  state_reg <= ST_RUN;
        default: state_reg <= ST_SYNC;
      endcase
    end
  end

  // Registered so the ready pin comes straight from a flop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= state_reg == ST_LOAD || run;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      page_reg <= `PMCB_PAGE_ALL;
    end else if (wr && cmd_code_in == `PMCB_C_PAGE) begin
      page_reg <= cmd_data_in[7:0];
    end
  end

  // Store and restore ignore the page: both channels move together
  // Memory image; resets stand in for contents held across power cycles
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < NSLOT; s++) begin
          nvm[c][s] <= dflt(c[0], s);
        end
      end
    end else if (wr && cmd_code_in == `PMCB_C_STORE) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < NSLOT; s++) begin
          if (storable(s)) begin
            nvm[c][s] <= regs[c][s];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < NSLOT; s++) begin
          regs[c][s] <= dflt(c[0], s);
        end
      end
    end else if (state_reg == ST_LOAD || (wr && cmd_code_in == `PMCB_C_RESTORE)) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < NSLOT; s++) begin
          if (storable(s)) begin
            regs[c][s] <= nvm[c][s];
          end
        end
      end
      if (state_reg == ST_LOAD && strap_s_reg) begin
        regs[0][SL_VCMD] <= code_s_reg;
        regs[0][SL_VMAX] <= `PMCB_VMAX_PIN;
      end
    end else if (wr && dec[6]) begin
      // Read-only codes never decode, so they store nothing
      for (int c = 0; c < 2; c++) begin
        if (sel[c]) begin
          regs[c][slot] <= is_byte(slot) ? (cmd_data_in & `PMCB_BYTE_MSK) : cmd_data_in;
        end
      end
    end
  end

  // Page 0xFF reads back channel A
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out  <= `PMCB_ZERO;
      rd_valid_out <= 1'b0;
      cmd_err_out  <= 1'b0;
    end else begin
      rd_valid_out <= rd;
      cmd_err_out  <= (rd && !dec[6] && !ro_hit && cmd_code_in != `PMCB_C_PAGE) ||
                      (wr && ro_hit);
      if (rd) begin
        if (cmd_code_in == `PMCB_C_PAGE) begin
          rd_data_out <= {8'h00, page_reg};
        end else if (cmd_code_in == `PMCB_C_VMODE) begin
          rd_data_out <= `PMCB_VMODE_VAL;
        end else if (ro_hit) begin
          rd_data_out <= `PMCB_OTHER_VAL;
        end else if (dec[6]) begin
          rd_data_out <= regs[!sel[0]][slot];
        end else begin
          rd_data_out <= `PMCB_ZERO;
        end
      end
    end
  end

  // Faults count only while the channel runs, so a soft start is not a trip
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      logic [1:0] t;
      t = trip(meas_in[c].vout > regs[c][SL_OVF], regs[c][SL_OVR]) |
          trip(meas_in[c].vout < regs[c][SL_UVF], regs[c][SL_UVR]) |
          trip(meas_in[c].iout > regs[c][SL_OCF] ||
               meas_in[c].iphase > regs[c][SL_OCPH], regs[c][SL_OCR]) |
          trip(meas_in[c].temp > regs[c][SL_OTF], regs[c][SL_OTR]) |
          trip(vin_in > regs[c][SL_VINOVF], regs[c][SL_VINOVR]);
      imm_trip[c] = chan_on_out[c] & t[1];
      del_trip[c] = chan_on_out[c] & t[0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dly_cnt_reg[0] <= '0;
      dly_cnt_reg[1] <= '0;
      fault_out      <= 2'b00;
      chan_on_out    <= 2'b00;
      warn_out       <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        dly_cnt_reg[c] <= del_trip[c] ? dly_cnt_reg[c] + 1'b1 : '0;
        // A trip in the clearing cycle still latches
        fault_out[c] <= (fault_out[c] & !clr_hit[c]) | imm_trip[c] |
                        (del_trip[c] && dly_cnt_reg[c] == UV_LAST);
        chan_on_out[c] <= run & en_s_reg[c] & !fault_out[c] & !imm_trip[c];
        // Warnings follow the measurement and never latch
        warn_out[c] <= chan_on_out[c] & (meas_in[c].vout > regs[c][SL_OVW] ||
                       meas_in[c].vout < regs[c][SL_UVW] ||
                       meas_in[c].iout > regs[c][SL_OCW] ||
                       meas_in[c].temp > regs[c][SL_OTW] ||
                       vin_in > regs[c][SL_VINOVW]);
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Command path, plus the strap ceiling at power-up load
  a_vmode_fixed: assert property (rd && cmd_code_in == `PMCB_C_VMODE |=>
    rd_data_out == `PMCB_VMODE_VAL) else $error("output format read wrong");
  a_other_mask: assert property (rd && ro_hit && cmd_code_in == `PMCB_C_MASK |=>
    rd_data_out == `PMCB_OTHER_VAL && cmd_err_out == 1'b0) else $error("misc mask wrong");
  a_strap_ceiling: assert property (state_reg == ST_LOAD && strap_s_reg |=>
    regs[0][SL_VMAX] == `PMCB_VMAX_PIN ##1 run) else $error("strap ceiling missed");
  a_page_isolate: assert property (wr && page_reg == `PMCB_PAGE_B && dec[6] |=>
    regs[0][$past(slot)] == $past(regs[0][slot])) else $error("page B write hit A");
  // Fault path, then store, restore, power-up load and read-only write
  a_uv_delay: assert property (del_trip[0] && dly_cnt_reg[0] == UV_LAST |=>
    fault_out[0] ##1 !chan_on_out[0]) else $error("delayed latch-off missed");
  a_uv_not_early: assert property ($rose(fault_out[0]) |->
    $past(imm_trip[0]) || $past(dly_cnt_reg[0]) == UV_LAST) else $error("early latch");
  a_latch_holds: assert property (fault_out[0] && !clr_hit[0] |=>
    fault_out[0] && !chan_on_out[0]) else $error("latched fault released");
  a_store_copy: assert property (wr && cmd_code_in == `PMCB_C_STORE |=>
    nvm[1][SL_OVF] == $past(regs[1][SL_OVF]) && nvm[0][SL_PMODE] == $past(nvm[0][SL_PMODE]))
    else $error("store copy wrong");
  a_restore_copy: assert property (wr && cmd_code_in == `PMCB_C_RESTORE |=>
    regs[0][SL_UVF] == $past(nvm[0][SL_UVF])) else $error("restore copy wrong");
  a_init_load: assert property (state_reg == ST_LOAD |=>
    regs[1][SL_VCMD] == $past(nvm[1][SL_VCMD])) else $error("power-up load wrong");
  a_ro_write: assert property (wr && ro_hit |=> cmd_err_out) else $error("ro write no error");

  c_store: cover property (wr && cmd_code_in == `PMCB_C_STORE);
  c_uv_latch: cover property (del_trip[0] && dly_cnt_reg[0] == UV_LAST);
  c_clear_fault: cover property (fault_out[1] && clr_hit[1]);
  c_warn_only: cover property (warn_out[0] && !fault_out[0]);
  c_page_b_write: cover property (wr && page_reg == `PMCB_PAGE_B && dec[6]);

  a_ready_rise: assert property (state_reg == ST_LOAD |=>
    ready_out && run) else $error("ready not raised after load");
  a_page_both: assert property (wr && page_reg == `PMCB_PAGE_ALL && dec[6] |=>
    regs[0][$past(slot)] == regs[1][$past(slot)]) else $error("page all write split");
  a_clear_page: assert property (clr_hit[1] && !imm_trip[1] && !del_trip[1] |=>
    !fault_out[1]) else $error("clear faults missed");
  a_ov_latch: assert property (chan_on_out[1] && meas_in[1].vout > regs[1][SL_OVF] &&
    regs[1][SL_OVR][`PMCB_RSP_HI] |=> fault_out[1] && !chan_on_out[1])
    else $error("overvoltage trip missed");
  a_warn_cross: assert property (chan_on_out[0] && meas_in[0].vout > regs[0][SL_OVW] |=>
    warn_out[0]) else $error("overvoltage caution missed");
  a_uv_arm: assert property (chan_on_out[0] && meas_in[0].vout < regs[0][SL_UVF] &&
    !regs[0][SL_UVR][`PMCB_RSP_HI] && regs[0][SL_UVR][`PMCB_RSP_LO] |-> del_trip[0])
    else $error("undervoltage compare missed");
endmodule : pmcb_bank

// ### verif/pmcb_host.sv
module pmcb_host (
  // Clock
  input  wire logic        clk_in,
  // Command port toward the bank
  output logic             cmd_valid_out,
  output logic             cmd_write_out,
  output logic [7:0]       cmd_code_out,
  output logic [7:0]       cmd_sub_out,
  output logic [15:0]      cmd_data_out,
  // Answers from the bank
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  input  wire logic        cmd_err_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_code_out  = 8'hFF;
    cmd_sub_out   = 8'hFF;
    cmd_data_out  = 16'hFFFF;
  end

  // Entered at a rising edge; the request stands until the taking edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] s,
                      input logic [15:0] d, output logic [15:0] q, output logic e);
    int n;
    cmd_valid_out <= 1'b1;
    cmd_write_out <= w;
    cmd_code_out  <= c;
    cmd_sub_out   <= s;
    cmd_data_out  <= d;
    @(posedge clk_in);
    // Released lines show inverted values so stale data never looks valid
    cmd_valid_out <= 1'b0;
    cmd_code_out  <= ~c;
    cmd_sub_out   <= ~s;
    cmd_data_out  <= ~d;
    q = 16'hDEAD;
    e = 1'b0;
    for (n = 0; n < 3; n++) begin
      #1;
      // Answers count only in the cycle right after the taking edge
      if (n == 0 && cmd_err_in === 1'b1) e = 1'b1;
      if (n == 0 && rd_valid_in === 1'b1) q = rd_data_in;
      @(posedge clk_in);
    end
  endtask : xfer
endmodule : pmcb_host

// ### verif/pmcb_bank_tb.sv
module pmcb_bank_tb import pmcb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk, rst, strap, v, w, rv, er, rdy;
  logic [7:0]        code, sub;
  logic [15:0]       d, rdat, q_last;
  logic              e_last;
  logic [1:0]        en, on, flt, wrn;
  logic [1:0][15:0]  sp;
  pmcb_meas_t [1:0]  meas;
  int                fail_count, compares, i;
  // Entry: page, code, sub, expected value
  localparam logic [39:0] TBL [23] = '{
    40'h00_1B_7C_0008, 40'h00_1B_7F_000D, 40'h00_1B_7A_0000, 40'h00_1B_80_0006,
    40'h00_1B_7D_0000, 40'h00_1B_7E_0000, 40'h00_1B_7B_0000, 40'h00_20_00_0016,
    40'h00_21_00_0400, 40'h00_24_00_077A, 40'h00_40_00_044A, 40'h00_42_00_0439,
    40'h00_43_00_02D1, 40'h00_44_00_02C0, 40'h00_45_00_0040, 40'h00_41_00_0080,
    40'h00_47_00_00C0, 40'h00_34_00_0003, 40'h00_39_00_E800, 40'h00_46_00_10E0,
    40'h00_46_01_0035, 40'h01_21_00_0333, 40'h01_24_00_059A};

  pmcb_host host (.clk_in(clk), .cmd_valid_out(v), .cmd_write_out(w), .cmd_code_out(code),
    .cmd_sub_out(sub), .cmd_data_out(d), .rd_data_in(rdat), .rd_valid_in(rv), .cmd_err_in(er));

  pmcb_bank uut (.clk_in(clk), .rst_in(rst), .cmd_valid_in(v), .cmd_write_in(w),
    .cmd_code_in(code), .cmd_sub_in(sub), .cmd_data_in(d), .rd_data_out(rdat),
    .rd_valid_out(rv), .cmd_err_out(er), .boot_voltage_strap_a_in(strap),
    .boot_code_in(16'h0400), .chan_en_in(en), .meas_in(meas), .vin_in(16'h000C),
    .ready_out(rdy), .chan_on_out(on), .fault_out(flt), .warn_out(wrn), .setpoint_out(sp));

  always #2.5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] c, input logic [7:0] s, input logic [15:0] x);
    host.xfer(1'b1, c, s, x, q_last, e_last);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [7:0] s);
    host.xfer(1'b0, c, s, 16'h0000, q_last, e_last);
  endtask : rd

  task automatic setv(input logic [15:0] a, input logic [15:0] b);
    meas[0].vout <= a;
    meas[1].vout <= b;
  endtask : setv

  task automatic print_verdict;
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #60000;
    fail_count++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    strap = 1'b1;
    en = 2'b00;
    fail_count = 0;
    compares = 0;
    for (i = 0; i < 2; i++) meas[i] = '{16'h0385, 16'h0010, 16'h0010, 16'h0019};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk);
    chk({15'h0, rdy}, 16'h0001);
    // Power-up contents, both pages
    for (i = 0; i < 23; i++) begin
      wr(8'h00, 8'h00, {8'h00, TBL[i][39:32]});
      rd(TBL[i][31:24], TBL[i][23:16]);
      chk(q_last, TBL[i][15:0]);
    end
    // Read-only places refuse writes
    wr(8'h00, 8'h00, 16'h0000);
    wr(8'h20, 8'h00, 16'h00FF);
    chk({15'h0, e_last}, 16'h0001);
    wr(8'h1B, 8'h7F, 16'h0000);
    chk({15'h0, e_last}, 16'h0001);
    rd(8'h20, 8'h00);
    chk(q_last, 16'h0016);
    rd(8'h1B, 8'h7F);
    chk(q_last, 16'h000D);
    // Paging: B only, then both
    wr(8'h00, 8'h00, 16'h0001);
    rd(8'h00, 8'h00);
    chk(q_last, 16'h0001);
    wr(8'h21, 8'h00, 16'h0300);
    chk(sp[1], 16'h0300);
    chk(sp[0], 16'h0400);
    wr(8'h00, 8'h00, 16'h00FF);
    wr(8'h22, 8'h00, 16'h0011);
    rd(8'h22, 8'h00);
    chk(q_last, 16'h0011);
    wr(8'h00, 8'h00, 16'h0001);
    rd(8'h22, 8'h00);
    chk(q_last, 16'h0011);
    // Store, overwrite, restore; phase mode is not among the stored set
    wr(8'h00, 8'h00, 16'h0000);
    wr(8'h40, 8'h00, 16'h0500);
    wr(8'h15, 8'h00, 16'h0000);
    wr(8'h40, 8'h00, 16'h0600);
    wr(8'h34, 8'h00, 16'h0001);
    wr(8'h16, 8'h00, 16'h0000);
    rd(8'h40, 8'h00);
    chk(q_last, 16'h0500);
    rd(8'h34, 8'h00);
    chk(q_last, 16'h0001);
    // Faults with both channels on
    en <= 2'b11;
    repeat (8) @(posedge clk);
    chk({12'h0, on, flt}, 16'h000C);
    setv(16'h043F, 16'h0385);
    repeat (6) @(posedge clk);
    #1;
    chk({12'h0, wrn, flt}, 16'h0004);
    @(posedge clk);
    setv(16'h0385, 16'h0500);
    repeat (3) @(posedge clk);
    #1;
    chk({14'h0, flt}, 16'h0002);
    repeat (3) @(posedge clk);
    #1;
    chk({14'h0, on}, 16'h0001);
    @(posedge clk);
    setv(16'h0200, 16'h0385);
    repeat (999) @(posedge clk);
    #1;
    chk({12'h0, wrn, flt}, 16'h0006);
    @(posedge clk);
    #1;
    chk({14'h0, flt}, 16'h0003);
    @(posedge clk);
    setv(16'h0385, 16'h0385);
    wr(8'h00, 8'h00, 16'h0001);
    wr(8'h03, 8'h00, 16'h0000);
    repeat (4) @(posedge clk);
    #1;
    chk({14'h0, flt}, 16'h0001);
    // Second reset with the strap low: stored ceiling and setpoint apply
    @(posedge clk);
    rst <= 1'b1;
    strap <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk);
    chk({15'h0, rdy}, 16'h0001);
    wr(8'h00, 8'h00, 16'h0000);
    rd(8'h24, 8'h00);
    chk(q_last, 16'h04CD);
    rd(8'h21, 8'h00);
    chk(q_last, 16'h0385);
    print_verdict();
  end
endmodule : pmcb_bank_tb
